/* File: mbw_params.svh */
// Constants of the multiple-register write and read/write engine.
// Assumes inclusion by bare name from every file that needs them.
`ifndef MBW_PARAMS_SVH
`define MBW_PARAMS_SVH

// ==========================================================
// Function, error and exception codes
`define MBW_FC_WRITE_MULTI 8'h10
`define MBW_FC_READ_WRITE 8'h17
`define MBW_ERR_FLAG 8'h80
`define MBW_EXC_ILL_FUNC 8'h01
`define MBW_EXC_ILL_VALUE 8'h03

// ==========================================================
// Count limits and length fields
`define MBW_CNT_MIN 16'h0001
`define MBW_WR_CNT_MAX 16'h007B
`define MBW_RW_CNT_MAX 16'h0079
`define MBW_WR_LEN_BASE 16'h0007
`define MBW_RW_LEN_BASE 16'h000B
`define MBW_WR_RSP_LEN 16'h0006
`define MBW_RW_RSP_LEN_BASE 16'h0003
`define MBW_EXC_RSP_LEN 16'h0003

// ==========================================================
// Byte positions within a frame, counted from the first header byte
`define MBW_IDX_UID 17'h00006
`define MBW_IDX_FC 17'h00007
`define MBW_HDR_TAIL 17'h00005
`define MBW_WR_BC_IDX 17'h0000C
`define MBW_RW_BC_IDX 17'h00010
`define MBW_TX_EXC_TOTAL 9'h009
`define MBW_TX_WR_TOTAL 9'h00C
`define MBW_TX_DATA_START 9'h009

// ==========================================================
// Response buffer shape
`define MBW_FIFO_DEPTH 16
`define MBW_FIFO_WIDTH 8

`endif

/* File: mbw_pkg.sv */
// Types shared by the engine, its assertions and the bench.
// Assumes nothing beyond a SystemVerilog compiler.
package mbw_pkg;

  // ==========================================================
  // Data types
  typedef logic [7:0] mbw_byte_t;   // One stream byte
  typedef logic [15:0] mbw_word_t;  // One register value or address

  // ==========================================================
  // Engine states
  typedef enum logic [1:0] {
    MBW_S_RX,      // Taking request bytes
    MBW_S_TX,      // Building response bytes
    MBW_S_RDWAIT,  // Read strobe is out
    MBW_S_RDCAP    // Read data is on the port
  } mbw_state_t;

endpackage

/* File: mbw_fifo.sv */
// Byte FIFO between the response builder and the outgoing stream.
// Assumes one clock; the output stage is registered so the top sees flops.
`timescale 1ns/10ps
`include "mbw_params.svh"

module mbw_fifo #(
  parameter int WIDTH = `MBW_FIFO_WIDTH,
  parameter int DEPTH = `MBW_FIFO_DEPTH
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [WIDTH-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  output logic [WIDTH-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  // ==========================================================
  // Storage and pointers
  logic [WIDTH-1:0] mem [DEPTH];  // Word store
  logic [AW-1:0] wr_ptr_r, wr_ptr_nxt;  // Fill position
  logic [AW-1:0] rd_ptr_r, rd_ptr_nxt;  // Drain position
  logic [AW:0] count_r, count_nxt;  // Words held in the store
  logic [WIDTH-1:0] dout_r, dout_nxt;  // Output stage data
  logic dout_vld_r, dout_vld_nxt;  // Output stage holds a word
  logic push, pop;

  // Full only when every slot holds a word; the output stage is extra
  assign in_ready_out = (count_r != (AW+1)'(DEPTH));
  assign out_data_out = dout_r;
  assign out_valid_out = dout_vld_r;

  // ==========================================================
  // Next pointers, count and output stage
  always_comb begin
    push = in_valid_in && in_ready_out;
    // Refill the output stage whenever it empties or is taken
    pop = (count_r != '0) && (!dout_vld_r || out_ready_in);
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    dout_nxt = dout_r;
    dout_vld_nxt = dout_vld_r;
    if (push) begin
      wr_ptr_nxt = (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + AW'(1);
    end
    if (pop) begin
      rd_ptr_nxt = (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + AW'(1);
      dout_nxt = mem[rd_ptr_r];
      dout_vld_nxt = 1'b1;
    end else if (out_ready_in) begin
      dout_vld_nxt = 1'b0;  // Taken with nothing behind it
    end
    count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  // Control registers
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      dout_r <= '0;
      dout_vld_r <= 1'b0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r <= count_nxt;
      dout_r <= dout_nxt;
      dout_vld_r <= dout_vld_nxt;
    end
  end

  // Data store needs no reset; nothing reads a slot before it is written
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data_in;
    end
  end
endmodule

/* File: mbw_core.sv */
// Request parser and response builder for multi-register write (0x10)
// and read/write (0x17) frames with the seven-byte TCP header.
// Assumes request bytes and register port on the same clock as this logic.
`timescale 1ns/10ps
`include "mbw_params.svh"

module mbw_core #(
  parameter int FIFO_DEPTH = `MBW_FIFO_DEPTH
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire mbw_pkg::mbw_byte_t rx_data_in,
  input wire logic rx_valid_in,
  output logic rx_ready_out,
  output mbw_pkg::mbw_byte_t tx_data_out,
  output logic tx_valid_out,
  input wire logic tx_ready_in,
  output logic reg_wr_en_out,
  output mbw_pkg::mbw_word_t reg_wr_addr_out,
  output mbw_pkg::mbw_word_t reg_wr_data_out,
  output logic reg_rd_en_out,
  output mbw_pkg::mbw_word_t reg_rd_addr_out,
  input wire mbw_pkg::mbw_word_t reg_rd_data_in
);
  import mbw_pkg::*;

  // ==========================================================
  // Helpers
  // Byte count or length term for a register count
  function automatic mbw_word_t twice(input mbw_word_t cnt);
    twice = {cnt[14:0], 1'b0};
  endfunction

  // Count lies inside one to the given maximum
  function automatic logic cnt_ok(input mbw_word_t cnt, input mbw_word_t max);
    cnt_ok = (cnt >= `MBW_CNT_MIN) && (cnt <= max);
  endfunction

  // ==========================================================
  // State
  mbw_state_t state_r, state_nxt;  // Engine phase
  logic [16:0] idx_r, idx_nxt;  // Byte position in request
  mbw_word_t tid_r, tid_nxt;  // Transaction identifier
  mbw_word_t pid_r, pid_nxt;  // Protocol identifier
  mbw_word_t len_r, len_nxt;  // Header length field
  mbw_byte_t uid_r, uid_nxt;  // Unit identifier
  mbw_byte_t fc_r, fc_nxt;  // Function code
  mbw_word_t a1_r, a1_nxt;  // First start address
  mbw_word_t c1_r, c1_nxt;  // First count
  mbw_word_t a2_r, a2_nxt;  // Write start address of a read/write
  mbw_word_t c2_r, c2_nxt;  // Write count of a read/write
  mbw_byte_t ex_r, ex_nxt;  // Exception code, zero when none
  logic checked_r, checked_nxt;  // Counts passed their checks
  mbw_byte_t hi_r, hi_nxt;  // Held high byte of a value
  logic hi_have_r, hi_have_nxt;  // High byte is held
  mbw_word_t wk_r, wk_nxt;  // Values written so far
  logic [8:0] t_r, t_nxt;  // Response byte position
  mbw_word_t ridx_r, ridx_nxt;  // Values read so far
  mbw_word_t word_r, word_nxt;  // Read value being sent
  logic word_have_r, word_have_nxt;  // Read value is present
  logic rx_ready_r, rx_ready_nxt;
  logic wr_en_r, wr_en_nxt;
  mbw_word_t wr_addr_r, wr_addr_nxt;
  mbw_word_t wr_data_r, wr_data_nxt;
  logic rd_en_r, rd_en_nxt;
  mbw_word_t rd_addr_r, rd_addr_nxt;

  // Response path
  mbw_byte_t tx_byte;  // Byte offered to the buffer
  logic push;  // Byte goes into the buffer
  logic fifo_ready;  // Buffer has room
  logic is_data;  // Position carries read data
  logic [8:0] off;  // Offset into read data
  logic [8:0] tot;  // Response size in bytes
  mbw_word_t rsp_len;  // Response length field
  logic rx_take;  // Request byte accepted
  logic is_wr, is_rw;  // Function decode
  mbw_word_t wbase;  // Write start address in use
  logic [16:0] bc_idx;  // Position of the byte count

  assign rx_ready_out = rx_ready_r;
  assign reg_wr_en_out = wr_en_r;
  assign reg_wr_addr_out = wr_addr_r;
  assign reg_wr_data_out = wr_data_r;
  assign reg_rd_en_out = rd_en_r;
  assign reg_rd_addr_out = rd_addr_r;

  // ==========================================================
  // Response byte selection
  always_comb begin
    is_wr = (fc_r == `MBW_FC_WRITE_MULTI);
    is_rw = (fc_r == `MBW_FC_READ_WRITE);
    off = t_r - `MBW_TX_DATA_START;
    is_data = (ex_r == 8'h00) && is_rw && (t_r >= `MBW_TX_DATA_START);
    // Size of the reply follows its kind
    if (ex_r != 8'h00) begin
      rsp_len = `MBW_EXC_RSP_LEN;
      tot = `MBW_TX_EXC_TOTAL;
    end else if (is_wr) begin
      rsp_len = `MBW_WR_RSP_LEN;
      tot = `MBW_TX_WR_TOTAL;
    end else begin
      rsp_len = `MBW_RW_RSP_LEN_BASE + twice(c1_r);
      tot = `MBW_TX_DATA_START + 9'(twice(c1_r));
    end
    tx_byte = 8'h00;
    if (is_data) begin
      tx_byte = off[0] ? word_r[7:0] : word_r[15:8];
    end else begin
      case (t_r)
        9'h000: tx_byte = tid_r[15:8];
        9'h001: tx_byte = tid_r[7:0];
        9'h002: tx_byte = pid_r[15:8];
        9'h003: tx_byte = pid_r[7:0];
        9'h004: tx_byte = rsp_len[15:8];
        9'h005: tx_byte = rsp_len[7:0];
        9'h006: tx_byte = uid_r;
        // Error code sets the top bit of the function code
        9'h007: tx_byte = (ex_r != 8'h00) ? (fc_r | `MBW_ERR_FLAG) : fc_r;
        9'h008: begin
          if (ex_r != 8'h00) begin
            tx_byte = ex_r;
          end else if (is_wr) begin
            tx_byte = a1_r[15:8];
          end else begin
            tx_byte = 8'(twice(c1_r));
          end
        end
        9'h009: tx_byte = a1_r[7:0];
        9'h00A: tx_byte = c1_r[15:8];
        9'h00B: tx_byte = c1_r[7:0];
        default: tx_byte = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Parser and sequencer next state
  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    tid_nxt = tid_r;
    pid_nxt = pid_r;
    len_nxt = len_r;
    uid_nxt = uid_r;
    fc_nxt = fc_r;
    a1_nxt = a1_r;
    c1_nxt = c1_r;
    a2_nxt = a2_r;
    c2_nxt = c2_r;
    ex_nxt = ex_r;
    checked_nxt = checked_r;
    hi_nxt = hi_r;
    hi_have_nxt = hi_have_r;
    wk_nxt = wk_r;
    t_nxt = t_r;
    ridx_nxt = ridx_r;
    word_nxt = word_r;
    word_have_nxt = word_have_r;
    wr_en_nxt = 1'b0;
    wr_addr_nxt = wr_addr_r;
    wr_data_nxt = wr_data_r;
    rd_en_nxt = 1'b0;
    rd_addr_nxt = rd_addr_r;
    push = 1'b0;
    rx_take = rx_valid_in && rx_ready_r;
    // Write range of a read/write is its own field
    wbase = is_rw ? a2_r : a1_r;
    bc_idx = is_rw ? `MBW_RW_BC_IDX : `MBW_WR_BC_IDX;
    case (state_r)
      MBW_S_RX: begin
        if (rx_take) begin
          idx_nxt = idx_r + 17'h00001;
          // Field capture, high byte first
          case (idx_r)
            17'h00000: tid_nxt[15:8] = rx_data_in;
            17'h00001: tid_nxt[7:0] = rx_data_in;
            17'h00002: pid_nxt[15:8] = rx_data_in;
            17'h00003: pid_nxt[7:0] = rx_data_in;
            17'h00004: len_nxt[15:8] = rx_data_in;
            17'h00005: len_nxt[7:0] = rx_data_in;
            17'h00006: uid_nxt = rx_data_in;
            17'h00007: begin
              fc_nxt = rx_data_in;
              // Anything but the two handled codes is refused
              if (rx_data_in != `MBW_FC_WRITE_MULTI && rx_data_in != `MBW_FC_READ_WRITE) begin
                ex_nxt = `MBW_EXC_ILL_FUNC;
              end
            end
            17'h00008: a1_nxt[15:8] = rx_data_in;
            17'h00009: a1_nxt[7:0] = rx_data_in;
            17'h0000A: c1_nxt[15:8] = rx_data_in;
            17'h0000B: c1_nxt[7:0] = rx_data_in;
            17'h0000C: if (is_rw) a2_nxt[15:8] = rx_data_in;
            17'h0000D: if (is_rw) a2_nxt[7:0] = rx_data_in;
            17'h0000E: if (is_rw) c2_nxt[15:8] = rx_data_in;
            17'h0000F: if (is_rw) c2_nxt[7:0] = rx_data_in;
            default: ;
          endcase
          // Checks on the byte count byte, before any value arrives
          if (idx_r == bc_idx && ex_r == 8'h00) begin
            if (is_wr) begin
              checked_nxt = cnt_ok(c1_r, `MBW_WR_CNT_MAX)
                && (rx_data_in == 8'(twice(c1_r)))
                && (len_r == `MBW_WR_LEN_BASE + twice(c1_r));
            end else begin
              checked_nxt = cnt_ok(c1_r, `MBW_RW_CNT_MAX)
                && cnt_ok(c2_r, `MBW_RW_CNT_MAX)
                && (rx_data_in == 8'(twice(c2_r)))
                && (len_r == `MBW_RW_LEN_BASE + twice(c2_r));
            end
            if (!checked_nxt) begin
              ex_nxt = `MBW_EXC_ILL_VALUE;
            end
          end
          // Value bytes pair into words, high byte first
          if (idx_r > bc_idx && checked_r && ex_r == 8'h00) begin
            if (!hi_have_r) begin
              hi_nxt = rx_data_in;
              hi_have_nxt = 1'b1;
            end else begin
              hi_have_nxt = 1'b0;
              wr_en_nxt = 1'b1;
              wr_addr_nxt = wbase + wk_r;
              wr_data_nxt = {hi_r, rx_data_in};
              wk_nxt = wk_r + 16'h0001;
            end
          end
          // Frame ends where the length field says
          if (idx_r >= `MBW_IDX_UID && idx_r >= {1'b0, len_r} + `MBW_HDR_TAIL) begin
            if (ex_nxt == 8'h00 && !checked_nxt) begin
              ex_nxt = `MBW_EXC_ILL_VALUE;
            end
            idx_nxt = 17'h00000;
            t_nxt = 9'h000;
            state_nxt = MBW_S_TX;
          end
        end
      end
      MBW_S_TX: begin
        if (is_data && !word_have_r) begin
          // Reads run after every write of the frame
          rd_en_nxt = 1'b1;
          rd_addr_nxt = a1_r + ridx_r;
          state_nxt = MBW_S_RDWAIT;
        end else if (fifo_ready) begin
          push = 1'b1;
          t_nxt = t_r + 9'h001;
          if (is_data && off[0]) begin
            word_have_nxt = 1'b0;
            ridx_nxt = ridx_r + 16'h0001;
          end
          if (t_r == tot - 9'h001) begin
            // Clean slate for the next request
            state_nxt = MBW_S_RX;
            ex_nxt = 8'h00;
            fc_nxt = 8'h00;
            checked_nxt = 1'b0;
            hi_have_nxt = 1'b0;
            wk_nxt = 16'h0000;
            ridx_nxt = 16'h0000;
            word_have_nxt = 1'b0;
          end
        end
      end
      MBW_S_RDWAIT: state_nxt = MBW_S_RDCAP;
      MBW_S_RDCAP: begin
        word_nxt = reg_rd_data_in;  // Valid one cycle after the strobe
        word_have_nxt = 1'b1;
        state_nxt = MBW_S_TX;
      end
      default: state_nxt = MBW_S_RX;
    endcase
    // Input is held off while a reply is being built
    rx_ready_nxt = (state_nxt == MBW_S_RX);
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r <= MBW_S_RX;
      idx_r <= '0;
      tid_r <= '0;
      pid_r <= '0;
      len_r <= '0;
      uid_r <= '0;
      fc_r <= '0;
      a1_r <= '0;
      c1_r <= '0;
      a2_r <= '0;
      c2_r <= '0;
      ex_r <= '0;
      checked_r <= 1'b0;
      hi_r <= '0;
      hi_have_r <= 1'b0;
      wk_r <= '0;
      t_r <= '0;
      ridx_r <= '0;
      word_r <= '0;
      word_have_r <= 1'b0;
      rx_ready_r <= 1'b0;
      wr_en_r <= 1'b0;
      wr_addr_r <= '0;
      wr_data_r <= '0;
      rd_en_r <= 1'b0;
      rd_addr_r <= '0;
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      tid_r <= tid_nxt;
      pid_r <= pid_nxt;
      len_r <= len_nxt;
      uid_r <= uid_nxt;
      fc_r <= fc_nxt;
      a1_r <= a1_nxt;
      c1_r <= c1_nxt;
      a2_r <= a2_nxt;
      c2_r <= c2_nxt;
      ex_r <= ex_nxt;
      checked_r <= checked_nxt;
      hi_r <= hi_nxt;
      hi_have_r <= hi_have_nxt;
      wk_r <= wk_nxt;
      t_r <= t_nxt;
      ridx_r <= ridx_nxt;
      word_r <= word_nxt;
      word_have_r <= word_have_nxt;
      rx_ready_r <= rx_ready_nxt;
      wr_en_r <= wr_en_nxt;
      wr_addr_r <= wr_addr_nxt;
      wr_data_r <= wr_data_nxt;
      rd_en_r <= rd_en_nxt;
      rd_addr_r <= rd_addr_nxt;
    end
  end

  // ==========================================================
  // Response buffer; a stalled sink stalls the builder
  mbw_fifo #(
    .WIDTH(`MBW_FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .in_data_in(tx_byte),
    .in_valid_in(push),
    .in_ready_out(fifo_ready),
    .out_data_out(tx_data_out),
    .out_valid_out(tx_valid_out),
    .out_ready_in(tx_ready_in)
  );
endmodule

/* File: mbw_core_asserts.sv */
// Concurrent checks on the ports of the request/reply engine.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/10ps

module mbw_core_asserts
  import mbw_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire mbw_pkg::mbw_byte_t rx_data_in,
  input wire logic rx_valid_in,
  input wire logic rx_ready_out,
  input wire mbw_pkg::mbw_byte_t tx_data_out,
  input wire logic tx_valid_out,
  input wire logic tx_ready_in,
  input wire logic reg_wr_en_out,
  input wire mbw_pkg::mbw_word_t reg_wr_addr_out,
  input wire mbw_pkg::mbw_word_t reg_wr_data_out,
  input wire logic reg_rd_en_out,
  input wire mbw_pkg::mbw_word_t reg_rd_addr_out,
  input wire mbw_pkg::mbw_word_t reg_rd_data_in
);
  // ==========================================================
  // Single domain, so one default clock and reset
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);

  // ==========================================================
  // Register port
  property p_wr_pulse;
    reg_wr_en_out |=> !reg_wr_en_out;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe longer than one cycle");
  // Back-to-back writes only occur inside one frame
  property p_wr_addr_inc;
    reg_wr_en_out ##2 reg_wr_en_out |-> reg_wr_addr_out == $past(reg_wr_addr_out, 2) + 16'h0001;
  endproperty
  a_wr_addr_inc: assert property (p_wr_addr_inc) else $error("write address not consecutive");
  // Low byte of the value is the byte just taken
  property p_wr_lo_byte;
    reg_wr_en_out |-> reg_wr_data_out[7:0] == $past(rx_data_in);
  endproperty
  a_wr_lo_byte: assert property (p_wr_lo_byte) else $error("write value byte order wrong");
  property p_wr_on_take;
    reg_wr_en_out |-> $past(rx_valid_in && rx_ready_out);
  endproperty
  a_wr_on_take: assert property (p_wr_on_take) else $error("write without a request byte");
  property p_rd_pulse;
    reg_rd_en_out |=> !reg_rd_en_out;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe longer than one cycle");
  // Reads only once the whole request is in
  property p_rd_after_rx;
    reg_rd_en_out |-> !rx_ready_out;
  endproperty
  a_rd_after_rx: assert property (p_rd_after_rx) else $error("read during request intake");

  // ==========================================================
  // Reply stream
  property p_tx_hold;
    tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("reply byte dropped under stall");
  // Intake must reopen once the reply is built
  property p_ready_back;
    $fell(rx_ready_out) |-> ##[1:1000] rx_ready_out;
  endproperty
  a_ready_back: assert property (p_ready_back) else $error("intake never reopened");

  c_write: cover property (reg_wr_en_out);
  c_read: cover property (reg_rd_en_out);
  c_stall: cover property (tx_valid_out && !tx_ready_in);
endmodule

bind mbw_core mbw_core_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) mbw_core_asserts_i (
  .clk_in(clk_in), .arst_n_in(arst_n_in), .rx_data_in(rx_data_in),
  .rx_valid_in(rx_valid_in), .rx_ready_out(rx_ready_out), .tx_data_out(tx_data_out),
  .tx_valid_out(tx_valid_out), .tx_ready_in(tx_ready_in), .reg_wr_en_out(reg_wr_en_out),
  .reg_wr_addr_out(reg_wr_addr_out), .reg_wr_data_out(reg_wr_data_out),
  .reg_rd_en_out(reg_rd_en_out), .reg_rd_addr_out(reg_rd_addr_out),
  .reg_rd_data_in(reg_rd_data_in));

/* File: mbw_regs_model.sv */
// Register file standing behind the engine's register port.
// Assumes read data is wanted one cycle after the read strobe.
`timescale 1ns/10ps

module mbw_regs_model (
  input wire logic clk_in,
  input wire logic wr_en_in,
  input wire logic [15:0] wr_addr_in,
  input wire logic [15:0] wr_data_in,
  input wire logic rd_en_in,
  input wire logic [15:0] rd_addr_in,
  output logic [15:0] rd_data_out
);
  // ==========================================================
  // Storage and write tally
  logic [15:0] mem [logic [15:0]];  // Sparse, only touched words
  int wr_count = 0;  // Cleared by the bench before each request frame
  initial rd_data_out = 16'h0000;

  // Writes land at once; read answers next cycle, then data turns over
  // so a late capture by the engine sees garbage, not the old word
  always @(posedge clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] = wr_data_in;
      wr_count++;
    end
    if (rd_en_in) begin
      rd_data_out <= mem.exists(rd_addr_in) ? mem[rd_addr_in] : 16'hA5C3;
    end else begin
      rd_data_out <= ~rd_data_out;
    end
  end
endmodule

/* File: tb_top.sv */
// Self-checking bench for the multi-register write and read/write engine.
// Assumes a client driving request bytes and a sink with back-pressure.
`timescale 1ns/10ps
`include "mbw_params.svh"

module tb_top;
  import mbw_pkg::*;
  // ==========================================================
  // Stimulus and observation
  logic clk_in = 1'b0;
  logic arst_n_in, rx_valid_in, tx_ready_in;
  mbw_byte_t rx_data_in;
  logic rx_ready_out, tx_valid_out, reg_wr_en_out, reg_rd_en_out;
  mbw_byte_t tx_data_out;
  mbw_word_t reg_wr_addr_out, reg_wr_data_out, reg_rd_addr_out, reg_rd_data_in;
  int failures = 0;
  int cmp_count = 0;
  logic [7:0] fq [$];  // Request bytes
  logic [7:0] eq [$];  // Expected reply bytes

  always #5 clk_in = ~clk_in;

  mbw_core #(.FIFO_DEPTH(16)) mbw_core_i (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .rx_data_in(rx_data_in),
    .rx_valid_in(rx_valid_in), .rx_ready_out(rx_ready_out), .tx_data_out(tx_data_out),
    .tx_valid_out(tx_valid_out), .tx_ready_in(tx_ready_in), .reg_wr_en_out(reg_wr_en_out),
    .reg_wr_addr_out(reg_wr_addr_out), .reg_wr_data_out(reg_wr_data_out),
    .reg_rd_en_out(reg_rd_en_out), .reg_rd_addr_out(reg_rd_addr_out),
    .reg_rd_data_in(reg_rd_data_in));

  mbw_regs_model mbw_regs_model_i (
    .clk_in(clk_in), .wr_en_in(reg_wr_en_out), .wr_addr_in(reg_wr_addr_out),
    .wr_data_in(reg_wr_data_out), .rd_en_in(reg_rd_en_out), .rd_addr_in(reg_rd_addr_out),
    .rd_data_out(reg_rd_data_in));

  // ==========================================================
  // Verdict and comparison
  task automatic wrap_up;
    if (failures == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic hang;
    failures++;
    wrap_up();
  endtask

  // ==========================================================
  // Frame building, two-byte fields high byte first
  task automatic put_w(input logic [15:0] w);
    fq.push_back(w[15:8]);
    fq.push_back(w[7:0]);
  endtask
  task automatic exp_w(input logic [15:0] w);
    eq.push_back(w[15:8]);
    eq.push_back(w[7:0]);
  endtask
  task automatic rq_hdr(input logic [15:0] tid, len, input logic [7:0] uid, fc);
    fq.delete();
    put_w(tid);
    put_w(16'h0000);
    put_w(len);
    fq.push_back(uid);
    fq.push_back(fc);
  endtask
  // Reply header echoes transaction, protocol and unit ids
  task automatic rs_hdr(input logic [15:0] tid, len, input logic [7:0] uid, fc);
    eq.delete();
    exp_w(tid);
    exp_w(16'h0000);
    exp_w(len);
    eq.push_back(uid);
    eq.push_back(fc);
  endtask

  // ==========================================================
  // Stream drivers, all entered at a falling edge
  task automatic send_frame;
    int n;
    mbw_regs_model_i.wr_count = 0;
    for (int i = 0; i < fq.size(); i++) begin
      rx_data_in = fq[i];
      rx_valid_in = 1'b1;
      n = 0;
      while (rx_ready_out !== 1'b1 && n < 1000) begin
        @(negedge clk_in);
        n++;
      end
      if (n >= 1000) hang();
      @(negedge clk_in);
    end
    rx_valid_in = 1'b0;
  endtask

  // Sink stalls every third cycle to exercise the buffer hold
  task automatic get_reply;
    int i = 0, n = 0;
    while (i < eq.size() && n < 3000) begin
      tx_ready_in = (n % 3 != 2);
      if (tx_valid_out === 1'b1 && tx_ready_in) begin
        check("reply byte", {8'h00, tx_data_out}, {8'h00, eq[i]});
        i++;
      end
      n++;
      @(negedge clk_in);
    end
    tx_ready_in = 1'b0;
    if (i < eq.size()) hang();
    repeat (3) @(negedge clk_in);
    check("reply length", {15'h0000, tx_valid_out}, 16'h0000);
  endtask

  // ==========================================================
  // Scenarios
  task automatic s_write;
    rq_hdr(16'hA55A, 16'h000B, 8'h11, `MBW_FC_WRITE_MULTI);
    put_w(16'h1770);
    put_w(16'h0002);
    fq.push_back(8'h04);
    put_w(16'h0102);
    put_w(16'h0304);
    send_frame();
    rs_hdr(16'hA55A, `MBW_WR_RSP_LEN, 8'h11, `MBW_FC_WRITE_MULTI);
    exp_w(16'h1770);
    exp_w(16'h0002);
    get_reply();
    check("write count", 16'(mbw_regs_model_i.wr_count), 16'h0002);
    check("reg 1770", mbw_regs_model_i.mem[16'h1770], 16'h0102);
    check("reg 1771", mbw_regs_model_i.mem[16'h1771], 16'h0304);
  endtask

  // Largest legal count, last register at start plus 0x7A
  task automatic s_write_max;
    rq_hdr(16'h0102, 16'h00FD, 8'h01, `MBW_FC_WRITE_MULTI);
    put_w(16'hFF80);
    put_w(16'h007B);
    fq.push_back(8'hF6);
    for (int k = 0; k < 123; k++) put_w(16'h4000 + 16'(k));
    send_frame();
    rs_hdr(16'h0102, 16'h0006, 8'h01, `MBW_FC_WRITE_MULTI);
    exp_w(16'hFF80);
    exp_w(16'h007B);
    get_reply();
    check("write count max", 16'(mbw_regs_model_i.wr_count), 16'h007B);
    check("reg FFFA", mbw_regs_model_i.mem[16'hFFFA], 16'h407A);
  endtask

  // Count over limit, count zero, byte count not twice the count
  task automatic s_write_faults;
    logic [15:0] cnt [3] = '{16'h007C, 16'h0000, 16'h0002};
    logic [7:0] bc [3] = '{8'h02, 8'h00, 8'h03};
    logic [15:0] len [3] = '{16'h0009, 16'h0007, 16'h000B};
    for (int c = 0; c < 3; c++) begin
      rq_hdr(16'h3300 + 16'(c), len[c], 8'h05, `MBW_FC_WRITE_MULTI);
      put_w(16'h2000);
      put_w(cnt[c]);
      fq.push_back(bc[c]);
      for (int k = 7; k < len[c]; k++) fq.push_back(8'hEE);
      send_frame();
      rs_hdr(16'h3300 + 16'(c), `MBW_EXC_RSP_LEN, 8'h05, 8'h90);
      eq.push_back(`MBW_EXC_ILL_VALUE);
      get_reply();
      check("fault writes", 16'(mbw_regs_model_i.wr_count), 16'h0000);
    end
  endtask

  // Read range differs from write range
  task automatic s_read_write;
    mbw_regs_model_i.mem[16'h1388] = 16'h0240;
    mbw_regs_model_i.mem[16'h1389] = 16'h0000;
    rq_hdr(16'h7E81, 16'h000F, 8'h22, `MBW_FC_READ_WRITE);
    put_w(16'h1388);
    put_w(16'h0002);
    put_w(16'h1770);
    put_w(16'h0002);
    fq.push_back(8'h04);
    put_w(16'h0A0B);
    put_w(16'h0C0D);
    send_frame();
    rs_hdr(16'h7E81, 16'h0007, 8'h22, `MBW_FC_READ_WRITE);
    eq.push_back(8'h04);
    exp_w(16'h0240);
    exp_w(16'h0000);
    get_reply();
    check("rw writes", 16'(mbw_regs_model_i.wr_count), 16'h0002);
    check("reg 1771", mbw_regs_model_i.mem[16'h1771], 16'h0C0D);
  endtask

  // Read count over limit, then an unsupported function
  task automatic s_rw_faults;
    rq_hdr(16'h4444, 16'h000D, 8'h07, `MBW_FC_READ_WRITE);
    put_w(16'h1388);
    put_w(16'h007A);
    put_w(16'h1770);
    put_w(16'h0001);
    fq.push_back(8'h02);
    put_w(16'h9999);
    send_frame();
    rs_hdr(16'h4444, 16'h0003, 8'h07, 8'h97);
    eq.push_back(`MBW_EXC_ILL_VALUE);
    get_reply();
    check("rw fault writes", 16'(mbw_regs_model_i.wr_count), 16'h0000);
    rq_hdr(16'h5555, 16'h0006, 8'h08, 8'h05);
    put_w(16'h0001);
    put_w(16'h0002);
    send_frame();
    rs_hdr(16'h5555, 16'h0003, 8'h08, 8'h85);
    eq.push_back(`MBW_EXC_ILL_FUNC);
    get_reply();
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    arst_n_in = 1'b0;
    rx_valid_in = 1'b0;
    tx_ready_in = 1'b0;
    rx_data_in = 8'h00;
    repeat (4) @(negedge clk_in);
    arst_n_in = 1'b1;
    @(negedge clk_in);
    s_write();
    s_write_max();
    s_write_faults();
    s_read_write();
    s_rw_faults();
    wrap_up();
  end
endmodule
